// File: apc_pkg.sv
// Shared constants and types for the converter's parallel host port.
// Assumes host strobes arrive synchronous to sys_clk_in.
package apc_pkg;
    localparam int DATA_W = 12;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int CNT_W  = 12;

    // Written word layout
    localparam int        ADDR_HI    = 15;
    localparam int        ADDR_LO    = 14;
    localparam logic [1:0] ADDR_TEST = 2'h1;
    localparam logic [1:0] ADDR_CTRL = 2'h3;
    localparam int        START_POS  = 13;
    localparam int        CTYPE_HI   = 12;
    localparam int        CTYPE_LO   = 11;
    localparam int        CONV_POS   = 10;
    localparam int        BIP_POS    = 9;
    localparam int        TEST_W     = 14;

    // System calibration types
    localparam logic [1:0] CAL_FULL = 2'h0;
    localparam logic [1:0] CAL_GNOF = 2'h1;
    localparam logic [1:0] CAL_OFS  = 2'h2;
    localparam logic [1:0] CAL_GAIN = 2'h3;

    // Reset values and trim targets
    localparam logic [TEST_W-1:0] TEST_DEFAULT   = 14'h0000;
    localparam logic [WORD_W-1:0] TEST_RESTORE   = 16'h4000;
    localparam logic [DATA_W-1:0] TGT_MIDSCALE   = 12'h800;
    localparam logic [DATA_W-1:0] TGT_ZEROSCALE  = 12'h000;
    localparam logic [DATA_W-1:0] TGT_FULLSCALE  = 12'hfff;

    // Default phase lengths in cycles
    localparam logic [CNT_W-1:0] DAC_CYC_DEF  = 12'h800;
    localparam logic [CNT_W-1:0] GAIN_CYC_DEF = 12'h200;
    localparam logic [CNT_W-1:0] OFS_CYC_DEF  = 12'h200;
    localparam logic [CNT_W-1:0] CONV_CYC_DEF = 12'h010;

    typedef enum logic [1:0] {
        APC_PH_NONE, APC_PH_DAC, APC_PH_GAIN, APC_PH_OFS
    } apc_phase_t;

    typedef struct packed {
        logic              cs_n;
        logic              rd_n;
        logic              wr_n;
        logic              byte_sel;
        logic              conv_n;
        logic [DATA_W-1:0] data;
    } apc_host_t;
endpackage

// File: apc_parallel_port.sv
// Parallel host port with busy handshake and system calibration sequencing.
// Assumes all host pins are already synchronous to sys_clk_in.
// Summary of operation
// R01: Control write with calibration start bit launches the selected calibration.
// R02: Full system calibration starts DAC phase and raises busy after write.
// R03: Host holds full-scale input during the first phase.
// R04: Busy falls after DAC and gain phases complete.
// R05: Convert bit write or convert pulse starts offset phase, busy rises.
// R06: Busy falls when offset phase ends; calibration complete.
// R07: Gain-plus-offset runs the same two phases without the DAC phase.
// R08: Single offset or gain calibration holds busy from write to finish.
// R09: Host holds analog level until busy falls.
// R10: Host should repeat offset-then-gain pair twice.
// R11: At most three gain-plus-offset runs are ever needed.
// R12: Offset targets midscale bipolar or zero unipolar; gain targets full scale.
// R13: Byte select low gives low 12 bits; high gives upper 4 bits.
// R14: Host may read the halves in either order.
// R15: Chip select and read combine into a level read enable.
// R16: Host latches on read rising edge; lines then float.
// R17: Wide hosts need only one read.
// R18: Byte-wide hosts read twice, one read per half.
// R19: With read tied low, lines stay driven; data leads busy fall.
// R20: Read-only hosts may hold write strobe high.
// R21: Bus cycles are accepted at any time, even mid conversion.
// R22: Words are written as low byte then high byte on lines 0-7.
// R23: Write data is captured at the end of the combined write strobe.
// R24: Writing 0x4000 restores the test register default.
// R25: Low byte is staged; the word applies on the high-byte write.
`timescale 1ns/100ps
module apc_parallel_port
    import apc_pkg::*;
#(
    parameter logic [CNT_W-1:0] DAC_CYC  = DAC_CYC_DEF,
    parameter logic [CNT_W-1:0] GAIN_CYC = GAIN_CYC_DEF,
    parameter logic [CNT_W-1:0] OFS_CYC  = OFS_CYC_DEF,
    parameter logic [CNT_W-1:0] CONV_CYC = CONV_CYC_DEF
) (
    input  wire logic              sys_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              cs_n_in,
    input  wire logic              rd_n_in,
    input  wire logic              wr_n_in,
    input  wire logic              byte_select_in,
    input  wire logic              convert_start_n_in,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic [DATA_W-1:0] sample_in,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe_n_out,
    output logic                   busy_out,
    output apc_phase_t             cal_phase_out,
    output logic [DATA_W-1:0]      cal_target_out,
    output logic                   bipolar_out,
    output logic [TEST_W-1:0]      test_reg_out
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_CONV, ST_DAC, ST_GAIN, ST_WAIT_OFS, ST_OFS
    } apc_state_t;

    apc_host_t         host_q, host_p;
    apc_state_t        state, next_state;
    logic [CNT_W-1:0]  cnt, next_cnt;
    logic              busy, next_busy;
    logic              two_phase, next_two_phase;
    logic [BYTE_W-1:0] stage, next_stage;
    logic [DATA_W-1:0] result, next_result;
    logic [DATA_W-1:0] next_data;
    logic [DATA_W-1:0] next_target;
    apc_phase_t        next_phase;
    logic              next_bipolar;
    logic [TEST_W-1:0] next_test;

    logic              rd_act, wr_act, wr_end, conv_fall;
    logic [WORD_W-1:0] word;
    logic              ctrl_wr;

    // Combined strobes as level enables
    assign rd_act    = !host_q.cs_n && !host_q.rd_n; // R15
    assign wr_act    = !host_q.cs_n && !host_q.wr_n;
    // Write completes when the combined enable goes inactive
    assign wr_end    = !host_p.cs_n && !host_p.wr_n && !wr_act; // R23
    assign conv_fall = host_p.conv_n && !host_q.conv_n;
    // Lines 8-11 ignored; previous cycle holds the last valid data
    assign word      = {host_p.data[BYTE_W-1:0], stage}; // R22
    assign ctrl_wr   = wr_end && host_p.byte_sel
                       && word[ADDR_HI:ADDR_LO] == ADDR_CTRL;

    function automatic logic [DATA_W-1:0] read_mux(
        input logic sel, input logic [DATA_W-1:0] res
    );
        logic [WORD_W-1:0] w;
        w = {4'h0, res};
        read_mux = sel ? {4'h0, w[WORD_W-1:BYTE_W]} : w[DATA_W-1:0]; // R13
    endfunction

    always_comb begin
        next_state     = state;
        next_cnt       = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_busy      = busy;
        next_two_phase = two_phase;
        next_stage     = stage;
        next_result    = result;
        next_bipolar   = bipolar_out;
        next_test      = test_reg_out;
        // Low byte waits in staging until the high byte lands
        if (wr_end && !host_p.byte_sel) begin
            next_stage = host_p.data[BYTE_W-1:0]; // R25
        end
        if (wr_end && host_p.byte_sel
                && word[ADDR_HI:ADDR_LO] == ADDR_TEST) begin
            if (word == TEST_RESTORE) begin
                next_test = TEST_DEFAULT; // R24
            end else begin
                next_test = word[TEST_W-1:0];
            end
        end
        if (ctrl_wr) begin
            next_bipolar = word[BIP_POS];
        end
        case (state)
            ST_IDLE: begin
                // Writes in calibration phases still update registers
                if (ctrl_wr && word[START_POS]) begin // R01
                    next_busy = 1'b1; // R08
                    case (word[CTYPE_HI:CTYPE_LO])
                        CAL_FULL: begin
                            next_state     = ST_DAC; // R02
                            next_cnt       = DAC_CYC;
                            next_two_phase = 1'b1;
                        end
                        CAL_GNOF: begin
                            next_state     = ST_GAIN; // R07
                            next_cnt       = GAIN_CYC;
                            next_two_phase = 1'b1;
                        end
                        CAL_OFS: begin
                            next_state = ST_OFS;
                            next_cnt   = OFS_CYC;
                        end
                        default: begin
                            next_state     = ST_GAIN;
                            next_cnt       = GAIN_CYC;
                            next_two_phase = 1'b0;
                        end
                    endcase
                end else if (conv_fall || (ctrl_wr && word[CONV_POS])) begin
                    next_state = ST_CONV;
                    next_cnt   = CONV_CYC;
                    next_busy  = 1'b1;
                end
            end
            ST_CONV: begin
                // Result lands one cycle ahead of busy falling
                if (cnt == 12'h001) begin
                    next_result = sample_in; // R19
                end
                if (cnt == '0) begin
                    next_state = ST_IDLE;
                    next_busy  = 1'b0;
                end
            end
            ST_DAC: begin
                if (cnt == '0) begin
                    next_state = ST_GAIN;
                    next_cnt   = GAIN_CYC;
                end
            end
            ST_GAIN: begin
                if (cnt == '0) begin
                    next_busy  = 1'b0; // R04
                    next_state = two_phase ? ST_WAIT_OFS : ST_IDLE;
                end
            end
            ST_WAIT_OFS: begin
                if (conv_fall || (ctrl_wr && word[CONV_POS])) begin // R05
                    next_state = ST_OFS;
                    next_cnt   = OFS_CYC;
                    next_busy  = 1'b1;
                end
            end
            ST_OFS: begin
                if (cnt == '0) begin
                    next_state     = ST_IDLE; // R06
                    next_busy      = 1'b0;
                    next_two_phase = 1'b0;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_busy  = 1'b0;
            end
        endcase
        case (next_state)
            ST_DAC:  next_phase = APC_PH_DAC;
            ST_GAIN: next_phase = APC_PH_GAIN;
            ST_OFS:  next_phase = APC_PH_OFS;
            default: next_phase = APC_PH_NONE;
        endcase
        if (next_phase == APC_PH_OFS) begin
            next_target = next_bipolar ? TGT_MIDSCALE : TGT_ZEROSCALE; // R12
        end else begin
            next_target = TGT_FULLSCALE;
        end
        next_data = read_mux(host_q.byte_sel, next_result);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            host_q         <= '1;
            host_p         <= '1;
            state          <= ST_IDLE;
            cnt            <= '0;
            busy           <= 1'b0;
            two_phase      <= 1'b0;
            stage          <= '0;
            result         <= '0;
            data_out       <= '0;
            data_oe_n_out  <= 1'b1;
            busy_out       <= 1'b0;
            cal_phase_out  <= APC_PH_NONE;
            cal_target_out <= TGT_FULLSCALE;
            bipolar_out    <= 1'b0;
            test_reg_out   <= TEST_DEFAULT;
        end else begin
            host_q         <= '{cs_n_in, rd_n_in, wr_n_in, byte_select_in,
                                convert_start_n_in, data_in}; // R21
            host_p         <= host_q;
            state          <= next_state;
            cnt            <= next_cnt;
            busy           <= next_busy;
            two_phase      <= next_two_phase;
            stage          <= next_stage;
            result         <= next_result;
            data_out       <= next_data;
            // Tied-low strobes keep the lines driven permanently
            data_oe_n_out  <= !rd_act; // R15 R16
            busy_out       <= next_busy;
            cal_phase_out  <= next_phase;
            cal_target_out <= next_target;
            bipolar_out    <= next_bipolar;
            test_reg_out   <= next_test;
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_CAL_BUSY: assert property ( // R08
        state == ST_IDLE && ctrl_wr && word[START_POS] |=> busy_out)
        else $error("Busy not raised by calibration write");
    AST_FULL_DAC: assert property ( // R02
        state == ST_IDLE && ctrl_wr && word[START_POS]
        && word[CTYPE_HI:CTYPE_LO] == CAL_FULL
        |=> state == ST_DAC && cal_phase_out == APC_PH_DAC)
        else $error("Full calibration did not enter DAC phase");
    AST_GNOF_NO_DAC: assert property ( // R07
        state == ST_IDLE && ctrl_wr && word[START_POS]
        && word[CTYPE_HI:CTYPE_LO] == CAL_GNOF |=> state == ST_GAIN)
        else $error("Gain plus offset entered wrong phase");
    AST_GAIN_END: assert property ( // R04
        state == ST_GAIN && cnt == '0 && two_phase
        |=> !busy_out && state == ST_WAIT_OFS)
        else $error("Busy not dropped after gain phase");
    AST_OFS_START: assert property ( // R05
        state == ST_WAIT_OFS && conv_fall
        |=> busy_out && state == ST_OFS && cnt == OFS_CYC)
        else $error("Offset phase not started by convert pulse");
    AST_OFS_END: assert property ( // R06
        state == ST_OFS && cnt == '0 |=> !busy_out && state == ST_IDLE)
        else $error("Busy not dropped after offset phase");
    AST_TARGET: assert property ( // R12
        cal_phase_out == APC_PH_OFS |-> cal_target_out ==
        (bipolar_out ? TGT_MIDSCALE : TGT_ZEROSCALE))
        else $error("Offset trim target wrong for input mode");
    AST_READ_EN: assert property ( // R15
        !host_q.cs_n && !host_q.rd_n |=> !data_oe_n_out)
        else $error("Data lines not driven during read");
    AST_READ_OFF: assert property ( // R16
        host_q.cs_n || host_q.rd_n |=> data_oe_n_out)
        else $error("Data lines driven outside a read");
    AST_HIGH_BYTE: assert property ( // R13
        host_q.byte_sel |=> data_out == {8'h00, result[DATA_W-1:BYTE_W]})
        else $error("High byte read shows wrong lines");
    AST_LOW_BYTE: assert property ( // R13
        !host_q.byte_sel |=> data_out == result)
        else $error("Low byte read shows wrong lines");
    AST_DATA_LEAD: assert property ( // R19
        state == ST_CONV && cnt == '0 |=> $fell(busy_out)
        && data_out == $past(data_out) && result == $past(sample_in, 2))
        else $error("Result not ahead of busy fall");
    AST_STAGE: assert property ( // R25
        wr_end && !host_p.byte_sel |=> $stable(test_reg_out)
        && $stable(bipolar_out))
        else $error("Low byte applied before high byte");
endmodule

// File: apc_host_model.sv
// Host processor model driving the parallel port pins.
// Assumes the bench calls its tasks; pins move 1 ns after the clock rises.
`timescale 1ns/100ps
module apc_host_model
    import apc_pkg::*;
(
    input  wire logic sys_clk_in,
    output apc_host_t host_out
);
    initial host_out = {5'h1d, 12'h5a5};

    task automatic edge_n(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    // Strobe held n cycles; upper lines carry junk the device must ignore
    task automatic wr_byte(input logic bs, input logic [7:0] d, input int n);
        edge_n(1);
        host_out.cs_n = 1'b0;
        host_out.wr_n = 1'b0;
        host_out.byte_sel = bs;
        host_out.data = {4'($urandom), d};
        edge_n(n);
        host_out.cs_n = 1'b1;
        host_out.wr_n = 1'b1;
        edge_n(1);
        // Held data gone after hold time, no stale value left
        host_out.data = ~host_out.data;
        edge_n(2);
    endtask

    task automatic wr_word(input logic [15:0] w, input int n);
        wr_byte(1'b0, w[7:0], n);
        wr_byte(1'b1, w[15:8], n);
    endtask

    task automatic rd(input logic bs);
        edge_n(1);
        host_out.cs_n = 1'b0;
        host_out.rd_n = 1'b0;
        host_out.byte_sel = bs;
        edge_n(3);
        host_out.cs_n = 1'b1;
        host_out.rd_n = 1'b1;
        edge_n(3);
    endtask

    task automatic conv_pulse();
        edge_n(1);
        host_out.conv_n = 1'b0;
        edge_n(2);
        host_out.conv_n = 1'b1;
    endtask

    // Read-only hookup: select and read tied low, write left high
    task automatic tie_rd(input logic on);
        edge_n(1);
        host_out.cs_n = !on;
        host_out.rd_n = !on;
        host_out.byte_sel = 1'b0;
    endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the parallel port and calibration sequencing.
// Uses default phase counts; host pins come from the host model.
`timescale 1ns/100ps
module tb_top;
    import apc_pkg::*;
    logic              sys_clk;
    logic              rst_n;
    logic [DATA_W-1:0] sample;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] cal_target;
    logic [TEST_W-1:0] test_reg;
    logic              oe_n;
    logic              busy;
    logic              bip;
    logic              oe_d = 1'b1;
    logic              busy_d = 1'b0;
    apc_phase_t        cal_phase;
    apc_host_t         h;
    logic [DATA_W-1:0] exp_q[$];
    int                errors = 0;
    int                cmp_count = 0;
    // Longest phase plus margin; DAC phase is the long one
    localparam int     CAL_LIM = 3000;

    apc_host_model u_apc_host_model (.sys_clk_in(sys_clk), .host_out(h));

    // Default counts keep the run near eight and a half thousand cycles
    apc_parallel_port u_apc_parallel_port (
        .sys_clk_in(sys_clk), .rst_n_in(rst_n), .cs_n_in(h.cs_n),
        .rd_n_in(h.rd_n), .wr_n_in(h.wr_n), .byte_select_in(h.byte_sel),
        .convert_start_n_in(h.conv_n), .data_in(h.data),
        .sample_in(sample), .data_out(rd_data), .data_oe_n_out(oe_n),
        .busy_out(busy), .cal_phase_out(cal_phase),
        .cal_target_out(cal_target), .bipolar_out(bip),
        .test_reg_out(test_reg)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        if (errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk_st(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t status %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [DATA_W-1:0] got,
                          input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t read %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [1:0] st(input bit s);
        return s ? cal_phase : {1'b0, busy};
    endfunction

    // Bounded wait on busy (s=0) or phase (s=1)
    task automatic wait_st(input bit s, input logic [1:0] v, input int n);
        for (int i = 0; i < n && st(s) !== v; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (st(s) !== v) begin
            errors++;
            $display("[ERR] %0t state %h exp %h", $time, st(s), v);
            summarize();
        end
    endtask

    // Result shows on read enable or, tied low, on busy fall
    always @(negedge sys_clk) begin
        if (exp_q.size() > 0 && !oe_n && (oe_d || (busy_d && !busy)))
            chk_rd(rd_data, exp_q.pop_front());
        oe_d = oe_n;
        busy_d = busy;
    end

    initial begin
        logic [DATA_W-1:0] s;
        logic              b;
        rst_n = 1'b0;
        sample = 12'h000;
        void'($urandom(83454));
        repeat (5) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        chk_st(16'({busy, oe_n, bip, cal_target}), 16'h2fff);
        u_apc_host_model.wr_byte(1'b0, 8'hbc, 2);
        chk_st(16'(test_reg), 16'h0000);
        u_apc_host_model.wr_byte(1'b1, 8'h5a, 1);
        chk_st(16'(test_reg), 16'h1abc);
        sample = 12'($urandom);
        u_apc_host_model.conv_pulse();
        wait_st(1'b0, 2'h1, 4);
        u_apc_host_model.wr_word(16'h4021, 1);
        chk_st(16'(test_reg), 16'h0021);
        wait_st(1'b0, 2'h0, 40);
        exp_q.push_back({8'h00, sample[11:8]});
        u_apc_host_model.rd(1'b1);
        exp_q.push_back(sample);
        u_apc_host_model.rd(1'b0);
        chk_st(16'(oe_n), 16'h0001);
        s = sample;
        sample = 12'($urandom);
        exp_q.push_back(s);
        u_apc_host_model.tie_rd(1'b1);
        u_apc_host_model.conv_pulse();
        wait_st(1'b0, 2'h1, 4);
        exp_q.push_back(sample);
        wait_st(1'b0, 2'h0, 40);
        u_apc_host_model.tie_rd(1'b0);
        chk_st(16'(exp_q.size()), 16'h0000);
        // Conversion launched by the control word, halves in random order
        sample = 12'($urandom);
        u_apc_host_model.wr_word(16'hc400, 1);
        wait_st(1'b0, 2'h0, 40);
        b = 1'($urandom);
        exp_q.push_back(b ? {8'h00, sample[11:8]} : sample);
        u_apc_host_model.rd(b);
        exp_q.push_back(b ? sample : {8'h00, sample[11:8]});
        u_apc_host_model.rd(!b);
        chk_st(16'(exp_q.size()), 16'h0000);
        u_apc_host_model.wr_word(TEST_RESTORE, 2);
        chk_st(16'(test_reg), 16'h0000);
        sample = TGT_FULLSCALE;
        u_apc_host_model.wr_word(16'he200, 2);
        wait_st(1'b1, APC_PH_DAC, 4);
        chk_st(16'(busy), 16'h0001);
        wait_st(1'b1, APC_PH_GAIN, CAL_LIM);
        chk_st(16'(cal_target), 16'h0fff);
        wait_st(1'b0, 2'h0, CAL_LIM);
        u_apc_host_model.wr_word(16'hc600, 1);
        wait_st(1'b1, APC_PH_OFS, 4);
        chk_st(16'({busy, bip, cal_target}), 16'h3800);
        wait_st(1'b0, 2'h0, CAL_LIM);
        for (int i = 0; i < 3; i++) begin
            u_apc_host_model.wr_word(16'he800, i + 1);
            wait_st(1'b1, APC_PH_GAIN, 4);
            wait_st(1'b0, 2'h0, CAL_LIM);
            u_apc_host_model.conv_pulse();
            wait_st(1'b1, APC_PH_OFS, 4);
            chk_st(16'({busy, bip, cal_target}), 16'h2000);
            wait_st(1'b0, 2'h0, CAL_LIM);
        end
        for (int i = 0; i < 2; i++) begin
            sample = TGT_MIDSCALE;
            u_apc_host_model.wr_word(16'hf200, 2);
            wait_st(1'b1, APC_PH_OFS, 4);
            chk_st(16'({busy, bip, cal_target}), 16'h3800);
            wait_st(1'b0, 2'h0, CAL_LIM);
            sample = TGT_FULLSCALE;
            u_apc_host_model.wr_word(16'hf800, 2);
            wait_st(1'b1, APC_PH_GAIN, 4);
            chk_st(16'(cal_target), 16'h0fff);
            wait_st(1'b0, 2'h0, CAL_LIM);
        end
        summarize();
    end
endmodule
